// File: design/pms_pkg.sv
package pms_pkg;

  localparam logic [31:0] VEC_GEN_BEV0  = 32'hBFC00380;
  localparam logic [31:0] VEC_GEN_BEV1  = 32'h80000180;
  localparam logic [31:0] VEC_COLD      = 32'hBFC00000;
  localparam int          WAKE_SRC_W    = 20;
  localparam int          GPIO_W        = 16;
  localparam int          PLL_LOCK_NS   = 200000;
  localparam int          CLK_NS        = 40;
  localparam int          PLL_LOCK_CYC  = (PLL_LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RST_PULSE_CYC = 4;

  typedef enum logic [8:0] {
    PMS_FULL      = 9'h001,
    PMS_WAIT_IDLE = 9'h002,
    PMS_STANDBY   = 9'h004,
    PMS_SUSPEND   = 9'h008,
    PMS_HIB_CHECK = 9'h010,
    PMS_HIB_RST   = 9'h020,
    PMS_HIBERNATE = 9'h040,
    PMS_PLL_WAIT  = 9'h080,
    PMS_BATT_HOLD = 9'h100
  } pms_state_t;

  typedef enum logic [1:0] {
    PMS_MODE_FULL = 2'h0,
    PMS_MODE_STBY = 2'h1,
    PMS_MODE_SUSP = 2'h2,
    PMS_MODE_HIB  = 2'h3
  } pms_mode_t;

  typedef struct packed {
    logic standby_instruction;
    logic suspend_instruction;
    logic hibernate_instruction;
    logic past_writeback_stage;
  } pms_cmd_t;

  typedef struct packed {
    logic power_switch;
    logic [GPIO_W-1:0] gpio_wake;
    logic carrier_detect_n;
    logic card_irq;
    logic elapsed_time_alarm;
  } pms_wake_t;

  typedef struct packed {
    logic pipeline_clock_run;
    logic internal_bus_clock_run;
    logic interrupt_clock_out_run;
    logic pll_run;
  } pms_clk_t;

endpackage : pms_pkg

// File: design/pms_cycle_timer.sv
`timescale 1ns/1ns
module pms_cycle_timer #(
  parameter int COUNT = 16
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      done
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= W'(COUNT);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = (cnt_r == W'(1));
endmodule : pms_cycle_timer

// File: design/pms_sequencer.sv
`timescale 1ns/1ns
// Functional notes
// [R1] Leave full speed only on standby, suspend or hibernate instruction, matching mode.
// [R2] Real-time clock reset works in every mode, resets all units and clock.
// [R3] Full speed: all internal and bus clocks run, everything available.
// [R4] Standby: pipeline clock held high; PLL, timer, irq clock, bus clocks run.
// [R5] Standby: all peripherals keep operating, display and DMA included.
// [R6] Standby and suspend keep core caches and registers intact.
// [R7] Standby entry waits writeback passed and system bus idle, then stops.
// [R8] Any interrupt wakes standby; resume at general vector chosen by boot select.
// [R9] Suspend: pipeline and bus clocks high; PLL, timer, irq clock, RTC run.
// [R10] Suspend entry waits writeback, DRAM self-refresh, bus idle, then stops.
// [R11] Only bus-clock-free interrupts wake suspend; resume at general vector.
// [R12] Hibernate: all clocks but RTC held high, PLL stopped, monitor runs.
// [R13] Hibernate: after writeback, self-refresh, idle and clock stop, drop main power.
// [R14] With core supply removed only power, I/O, LED, RTC units keep state.
// [R15] Wake from hibernate starts at cold reset vector.
// [R16] Hibernate wake sources: power switch, sixteen GPIO, carrier, card, alarm.
// [R17] Hibernate checks pending interrupts first; only if none, stop and reset peripherals.
// [R18] Low battery refuses core activation even with a wake source present.
// [R19] Exactly one mode at a time; entry sequence completes before any wake.
// [R20] Wake restarts PLL if stopped; gated clocks released only after PLL stable.
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire pms_pkg::pms_cmd_t   cmd,
  input  wire logic                system_bus_idle,
  input  wire logic                dram_self_refresh,
  input  wire logic                irq_pending,
  input  wire logic                suspend_wake_irq,
  input  wire pms_pkg::pms_wake_t  wake,
  input  wire logic                low_battery_inhibit,
  input  wire logic                boot_vector_select,
  output pms_pkg::pms_clk_t        clk_en,
  output pms_pkg::pms_mode_t       mode,
  output logic                     main_power_enable,
  output logic                     periph_reset,
  output logic                     core_cold_reset,
  output logic                     core_resume,
  output logic [31:0]              resume_vector,
  output logic                     retain_core_state
);
  import pms_pkg::*;

  logic       rst_s1_r;
  logic       rst_s2_r;
  pms_state_t state_r;
  pms_state_t state_nxt;
  pms_mode_t  target_r;
  pms_mode_t  target_nxt;
  pms_clk_t   clk_en_r;
  pms_clk_t   clk_en_nxt;
  pms_mode_t  mode_r;
  logic       mpe_r;
  logic       prst_r;
  logic       crst_r;
  logic       resume_r;
  logic [31:0] vec_r;
  logic [31:0] vec_nxt;
  logic       retain_r;
  logic       pll_start;
  logic       pll_done;
  logic       hib_rst_done;

  // Reset released through two flops; async assert works in every mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r; // see [R2]
    end
  end

  wire logic any_instr     = cmd.standby_instruction | cmd.suspend_instruction | cmd.hibernate_instruction;
  wire logic instr_taken   = (state_r == PMS_FULL) & any_instr & cmd.past_writeback_stage; // see [R1]
  wire logic need_refresh  = (target_r == PMS_MODE_SUSP) | (target_r == PMS_MODE_HIB);
  wire logic entry_ready   = system_bus_idle & (~need_refresh | dram_self_refresh); // see [R7] [R10] [R13]
  wire logic hib_wake      = wake.power_switch | (|wake.gpio_wake) | ~wake.carrier_detect_n
                             | wake.card_irq | wake.elapsed_time_alarm; // see [R16]
  wire logic [31:0] gen_vec = boot_vector_select ? VEC_GEN_BEV1 : VEC_GEN_BEV0; // see [R8] [R11]

  assign pll_start = (state_nxt == PMS_PLL_WAIT) & (state_r != PMS_PLL_WAIT);

  pms_cycle_timer #(.COUNT(PLL_LOCK_CYCLES)) u_pll_timer (
    .clock (clock),
    .rst_n (rst_s2_r),
    .start (pll_start),
    .done  (pll_done)
  );

  pms_cycle_timer #(.COUNT(RST_PULSE_CYC)) u_rst_timer (
    .clock (clock),
    .rst_n (rst_s2_r),
    .start ((state_r == PMS_HIB_CHECK) & (state_nxt == PMS_HIB_RST)),
    .done  (hib_rst_done)
  );

  // One state at a time; entry states ignore wake until finished
  always_comb begin
    state_nxt  = state_r; // see [R19]
    target_nxt = target_r;
    vec_nxt    = vec_r;
    case (state_r)
      PMS_FULL: begin
        if (instr_taken) begin
          state_nxt = PMS_WAIT_IDLE;
          if (cmd.hibernate_instruction) begin
            target_nxt = PMS_MODE_HIB;
          end else if (cmd.suspend_instruction) begin
            target_nxt = PMS_MODE_SUSP;
          end else begin
            target_nxt = PMS_MODE_STBY;
          end
        end
      end
      PMS_WAIT_IDLE: begin
        if (entry_ready) begin
          case (target_r)
            PMS_MODE_SUSP: state_nxt = PMS_SUSPEND;
            PMS_MODE_HIB:  state_nxt = PMS_HIB_CHECK;
            default:       state_nxt = PMS_STANDBY;
          endcase
        end
      end
      PMS_STANDBY: begin
        if (irq_pending) begin // see [R8]
          state_nxt = PMS_FULL;
          vec_nxt   = gen_vec;
        end
      end
      PMS_SUSPEND: begin
        if (suspend_wake_irq) begin // see [R11]
          state_nxt = PMS_FULL;
          vec_nxt   = gen_vec;
        end
      end
      PMS_HIB_CHECK: begin
        // Pending request aborts hibernate back to full speed, clocks untouched
        if (irq_pending) begin // see [R17]
          state_nxt = PMS_FULL;
          vec_nxt   = gen_vec;
        end else begin
          state_nxt = PMS_HIB_RST;
        end
      end
      PMS_HIB_RST: begin
        if (hib_rst_done) begin
          state_nxt = PMS_HIBERNATE;
        end
      end
      PMS_HIBERNATE: begin
        if (hib_wake) begin
          state_nxt = low_battery_inhibit ? PMS_BATT_HOLD : PMS_PLL_WAIT; // see [R18]
        end
      end
      PMS_BATT_HOLD: begin
        if (!low_battery_inhibit) begin
          state_nxt = PMS_HIBERNATE;
        end
      end
      PMS_PLL_WAIT: begin
        if (pll_done) begin // see [R20]
          state_nxt = PMS_FULL;
          vec_nxt   = VEC_COLD; // see [R15]
        end
      end
      default: begin
        state_nxt = PMS_FULL;
      end
    endcase
  end

  // Clock gates follow the state; standby keeps bus clocks for peripherals
  always_comb begin
    clk_en_nxt = '{pipeline_clock_run: 1'b1, internal_bus_clock_run: 1'b1,
                   interrupt_clock_out_run: 1'b1, pll_run: 1'b1}; // see [R3]
    case (state_nxt)
      PMS_STANDBY: begin
        clk_en_nxt.pipeline_clock_run = 1'b0; // see [R4] [R5]
      end
      PMS_SUSPEND: begin
        clk_en_nxt.pipeline_clock_run     = 1'b0; // see [R9]
        clk_en_nxt.internal_bus_clock_run = 1'b0;
      end
      PMS_HIB_RST, PMS_HIBERNATE, PMS_BATT_HOLD: begin
        clk_en_nxt = '0; // see [R12]
      end
      PMS_PLL_WAIT: begin
        // Gated clocks stay off until lock time elapses
        clk_en_nxt         = '0; // see [R20]
        clk_en_nxt.pll_run = 1'b1;
      end
      default: begin
      end
    endcase
  end

  wire pms_mode_t mode_nxt =
    (state_nxt == PMS_STANDBY) ? PMS_MODE_STBY :
    (state_nxt == PMS_SUSPEND) ? PMS_MODE_SUSP :
    ((state_nxt == PMS_HIBERNATE) | (state_nxt == PMS_BATT_HOLD) | (state_nxt == PMS_PLL_WAIT)
     | (state_nxt == PMS_HIB_RST)) ? PMS_MODE_HIB : PMS_MODE_FULL;

  wire logic in_hib_nxt = (state_nxt == PMS_HIBERNATE) | (state_nxt == PMS_BATT_HOLD);

  always_ff @(posedge clock or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r  <= PMS_FULL;
      target_r <= PMS_MODE_FULL;
      clk_en_r <= '1;
      mode_r   <= PMS_MODE_FULL;
      mpe_r    <= 1'b1;
      prst_r   <= 1'b0;
      crst_r   <= 1'b0;
      resume_r <= 1'b0;
      vec_r    <= VEC_COLD;
      retain_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      target_r <= target_nxt;
      clk_en_r <= clk_en_nxt;
      mode_r   <= mode_nxt;
      mpe_r    <= ~in_hib_nxt; // see [R13] [R14]
      prst_r   <= (state_nxt == PMS_HIB_RST) | (state_nxt == PMS_BATT_HOLD); // see [R17]
      crst_r   <= (state_nxt == PMS_PLL_WAIT) | in_hib_nxt; // see [R15]
      resume_r <= (state_nxt == PMS_FULL) & (state_r != PMS_FULL);
      vec_r    <= vec_nxt;
      retain_r <= (state_nxt == PMS_STANDBY) | (state_nxt == PMS_SUSPEND); // see [R6]
    end
  end

  assign clk_en            = clk_en_r;
  assign mode              = mode_r;
  assign main_power_enable = mpe_r;
  assign periph_reset      = prst_r;
  assign core_cold_reset   = crst_r;
  assign core_resume       = resume_r;
  assign resume_vector     = vec_r;
  assign retain_core_state = retain_r;
endmodule : pms_sequencer

// File: verification/pms_sequencer_properties.sv
`timescale 1ns/1ns
module pms_sequencer_properties
  import pms_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = 8
) (
  input wire logic              clock,
  input wire logic              arst_n,
  input wire logic              system_bus_idle,
  input wire logic              dram_self_refresh,
  input wire logic              irq_pending,
  input wire logic              suspend_wake_irq,
  input wire logic              low_battery_inhibit,
  input wire logic              boot_vector_select,
  input wire pms_pkg::pms_clk_t clk_en,
  input wire pms_pkg::pms_mode_t mode,
  input wire logic              main_power_enable,
  input wire logic              core_resume,
  input wire logic [31:0]       resume_vector,
  input wire logic              retain_core_state
);
  localparam int LOCK_MAX = PLL_LOCK_CYCLES + 4;
  logic [31:0] gen_vec;
  assign gen_vec = boot_vector_select ? VEC_GEN_BEV1 : VEC_GEN_BEV0;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence bus_busy_s; !system_bus_idle [*2]; endsequence
  sequence dram_awake_s; !dram_self_refresh [*2]; endsequence
  sequence pll_settle_s; (clk_en == 4'h1) [*4]; endsequence
  logic [15:0] lock_cnt_r;
  // Length of the latest stretch with only the PLL running; cleared a cycle after it ends
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_r <= 16'h0;
    end else if (clk_en == 4'h1) begin
      lock_cnt_r <= lock_cnt_r + 16'h1;
    end else begin
      lock_cnt_r <= 16'h0;
    end
  end
  full_clocks_a: assert property (mode == PMS_MODE_FULL |-> clk_en == 4'hF)
    else $error("clock gated in full speed");
  standby_clocks_a: assert property (mode == PMS_MODE_STBY
    |-> clk_en == 4'h7 && retain_core_state)
    else $error("standby clocks wrong");
  suspend_clocks_a: assert property (mode == PMS_MODE_SUSP
    |-> clk_en == 4'h3 && retain_core_state)
    else $error("suspend clocks wrong");
  hib_power_a: assert property (!main_power_enable |-> clk_en == 4'h0 && mode == PMS_MODE_HIB)
    else $error("power dropped with clocks on");
  bus_wait_a: assert property (bus_busy_s ##0 mode == PMS_MODE_FULL |=> mode == PMS_MODE_FULL)
    else $error("entry while bus busy");
  dram_wait_a: assert property (dram_awake_s ##0 mode == PMS_MODE_FULL
    |=> mode inside {PMS_MODE_FULL, PMS_MODE_STBY})
    else $error("entry without self refresh");
  standby_wake_a: assert property (mode == PMS_MODE_STBY && irq_pending
    |=> core_resume && resume_vector == gen_vec)
    else $error("standby wake wrong");
  suspend_wake_a: assert property (mode == PMS_MODE_SUSP |=> core_resume == $past(suspend_wake_irq))
    else $error("suspend wake wrong");
  cold_vector_a: assert property (core_resume && $past(mode) == PMS_MODE_HIB
    |-> resume_vector == VEC_COLD)
    else $error("hibernate resume vector wrong");
  pll_lock_a: assert property ($rose(main_power_enable) |-> pll_settle_s ##[1:LOCK_MAX] core_resume)
    else $error("clocks released before lock");
  lock_time_a: assert property (core_resume && $past(mode) == PMS_MODE_HIB
    |-> lock_cnt_r == 16'(PLL_LOCK_CYCLES))
    else $error("lock wait length wrong");
  battery_hold_a: assert property (!main_power_enable && low_battery_inhibit |=> !main_power_enable)
    else $error("woke on low battery");
endmodule : pms_sequencer_properties

bind pms_sequencer pms_sequencer_properties #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_props (.clock, .arst_n,
  .system_bus_idle, .dram_self_refresh, .irq_pending, .suspend_wake_irq, .low_battery_inhibit,
  .boot_vector_select, .clk_en, .mode, .main_power_enable, .core_resume, .resume_vector, .retain_core_state);

// File: verification/pms_core_model.sv
`timescale 1ns/1ns
module pms_core_model
  import pms_pkg::*;
(
  input  wire logic              clock,
  input  wire pms_pkg::pms_clk_t clk_en,
  input  wire logic              sr_req,
  output logic                   system_bus_idle,
  output logic                   dram_self_refresh
);
  logic [7:0] lfsr_r = 8'hA5;
  logic [1:0] sr_cnt_r = 2'h0;
  // Stopped bus cannot carry traffic
  assign system_bus_idle = !clk_en.internal_bus_clock_run | lfsr_r[0];
  // Self refresh only after software sequence ran a while
  assign dram_self_refresh = sr_cnt_r == 2'h3;
  always_ff @(posedge clock) begin
    lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    sr_cnt_r <= !sr_req ? 2'h0 : sr_cnt_r + {1'b0, sr_cnt_r != 2'h3};
  end
endmodule : pms_core_model

// File: verification/pms_sequencer_tb.sv
`timescale 1ns/1ns
module pms_sequencer_tb;
  import pms_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, irq_pending = 1'b0, suspend_wake_irq = 1'b0, sr_req = 1'b0;
  logic low_battery_inhibit = 1'b0, boot_vector_select = 1'b0;
  logic system_bus_idle, dram_self_refresh, main_power_enable, periph_reset;
  logic core_cold_reset, core_resume, retain_core_state;
  logic [31:0] resume_vector, seed = 32'h926CE968;
  pms_cmd_t  cmd = '0;
  pms_wake_t wake = 20'h00004;
  pms_clk_t  clk_en;
  pms_mode_t mode;
  int n_fail = 0, total_checks = 0;

  always #20 clock = ~clock;

  pms_core_model u_model (.clock, .clk_en, .sr_req, .system_bus_idle, .dram_self_refresh);
  pms_sequencer #(.PLL_LOCK_CYCLES(8)) DUT (.clock, .arst_n, .cmd, .system_bus_idle, .dram_self_refresh,
    .irq_pending, .suspend_wake_irq, .wake, .low_battery_inhibit, .boot_vector_select, .clk_en, .mode,
    .main_power_enable, .periph_reset, .core_cold_reset, .core_resume, .resume_vector, .retain_core_state);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] gen_vec(logic b);
    return b ? VEC_GEN_BEV1 : VEC_GEN_BEV0;
  endfunction : gen_vec

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step(int n);
    repeat (n) @(negedge clock);
  endtask : step

  task automatic wait_mode(pms_mode_t m);
    for (int i = 0; i < 400 && mode !== m; i++) @(negedge clock);
    check("mode", 32'(mode), 32'(m));
  endtask : wait_mode

  // A missed pulse would leave the previous vector standing
  task automatic wait_resume();
    for (int i = 0; i < 400 && core_resume !== 1'b1; i++) @(negedge clock);
    check("resume", 32'(core_resume), 32'h1);
  endtask : wait_resume

  task automatic issue(int k);
    cmd = pms_cmd_t'((4'h8 >> k) | 4'h1);
    step(1);
    cmd = '0;
  endtask : issue

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #(40 * 30000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    step(4);
    arst_n = 1'b1;
    step(3);
    check("clk_en", 32'(clk_en), 32'hF);
    check("power", 32'(main_power_enable), 32'h1);
    for (int k = 0; k < 4; k++) begin
      boot_vector_select = k[0];
      sr_req = k[1];
      step(4);
      issue(k[1]);
      wait_mode(k[1] ? PMS_MODE_SUSP : PMS_MODE_STBY);
      check("clk_en", 32'(clk_en), k[1] ? 32'h3 : 32'h7);
      check("retain", 32'(retain_core_state), 32'h1);
      step(32'(rnd() % 8) + 2);
      irq_pending = 1'b1;
      if (k[1]) begin
        step(3);
        check("mode", 32'(mode), 32'(PMS_MODE_SUSP));
        suspend_wake_irq = 1'b1;
      end
      wait_resume();
      check("vector", resume_vector, gen_vec(boot_vector_select));
      {irq_pending, suspend_wake_irq, sr_req} = 3'h0;
      step(2);
    end
    sr_req = 1'b1;
    irq_pending = 1'b1;
    step(4);
    issue(2);
    wait_resume();
    check("vector", resume_vector, gen_vec(boot_vector_select));
    check("power", 32'(main_power_enable), 32'h1);
    irq_pending = 1'b0;
    for (int i = 0; i < 20; i++) begin
      boot_vector_select = 1'(rnd() % 2);
      low_battery_inhibit = (i % 5 == 0);
      step(4);
      issue(2);
      wait_mode(PMS_MODE_HIB);
      check("prst", 32'(periph_reset), 32'h1);
      step(8);
      check("power", 32'(main_power_enable), 32'h0);
      check("clk_en", 32'(clk_en), 32'h0);
      check("cold", 32'(core_cold_reset), 32'h1);
      wake = pms_wake_t'(20'h00004 ^ (20'h1 << i));
      step(4);
      if (low_battery_inhibit) begin
        check("prst", 32'(periph_reset), 32'h1);
        check("power", 32'(main_power_enable), 32'h0);
        low_battery_inhibit = 1'b0;
      end
      wait_resume();
      check("vector", resume_vector, VEC_COLD);
      wake = 20'h00004;
      step(2);
    end
    // Reset taken while hibernating must bring everything back
    issue(2);
    wait_mode(PMS_MODE_HIB);
    step(8);
    arst_n = 1'b0;
    step(2);
    check("mode", 32'(mode), 32'(PMS_MODE_FULL));
    arst_n = 1'b1;
    step(3);
    check("clk_en", 32'(clk_en), 32'hF);
    check("power", 32'(main_power_enable), 32'h1);
    check("vector", resume_vector, VEC_COLD);
    report_and_stop();
  end
endmodule : pms_sequencer_tb
